// [rtl/board_control_and_strap_logic.sv]
// Board control register bank and strap decoding
`timescale 1ns/1ps
`default_nettype none
module board_control_and_strap_logic #(
  parameter int POR_CYCLES = board_ctrl_pkg::POR_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Switches and straps (asynchronous)
  input wire logic i_config_source_switch,
  input wire logic i_boot_mode_switch,
  input wire logic i_boot_bank_switch,
  input wire logic [7:0] i_strap_bank,
  input wire logic [3:0] i_base_addr_switch_hi,
  input wire logic [3:0] i_base_addr_switch_mid,
  input wire logic [3:0] i_base_addr_switch_lo,
  input wire logic i_a24_mode,
  // Register port from VME slave
  input wire logic i_vme_sel,
  input wire logic i_vme_wr,
  input wire logic [7:0] i_vme_addr,
  input wire logic [7:0] i_vme_wdata,
  output logic [7:0] o_vme_rdata,
  // Register port from interface processor
  input wire logic i_cpu_sel,
  input wire logic i_cpu_wr,
  input wire logic [7:0] i_cpu_addr,
  input wire logic [7:0] i_cpu_wdata,
  output logic [7:0] o_cpu_rdata,
  // Status inputs (asynchronous)
  input wire logic i_subsys_error,
  input wire logic i_cpu_error,
  input wire logic i_link_adaptor_irq,
  // VME address decode helpers
  input wire logic [1:0] i_a24_window_req,
  output logic [7:0] o_a32_base,
  output logic [1:0] o_a24_base,
  output logic [21:0] o_shared_memory_window_base,
  output logic o_vme_slave_enable,
  // Config link routing
  output logic [1:0] o_upstream_config_link,
  output logic o_downstream_config_link_front,
  // Boot and links
  output logic o_boot_from_link,
  output logic o_boot_from_flash,
  output logic o_link_speed_10m,
  output logic o_subsys_fanout_from_site0,
  output logic o_backplane_system_reset,
  // Control outputs
  output logic o_subsys_reset,
  output logic o_subsys_analyse,
  output logic o_cpu_reset,
  output logic o_cpu_analyse,
  output logic [2:0] o_panel_lamps,
  output logic o_cpu_bus_hold,
  output logic o_backplane_bus_hold,
  output logic o_cpu_irq,
  output logic o_backplane_irq,
  output logic [2:0] o_backplane_irq_priority,
  output logic [7:0] o_backplane_irq_vector_num,
  output logic o_cpu_irq_ack,
  output logic o_flash_prog_voltage,
  output logic [1:0] o_flash_low_addr
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  localparam int NSYNC = 3 + 8 + 12 + 1 + 3;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] s1, s2, s3, stable;
  assign async_in = {i_config_source_switch, i_boot_mode_switch, i_boot_bank_switch, i_strap_bank,
                     i_base_addr_switch_hi, i_base_addr_switch_mid, i_base_addr_switch_lo, i_a24_mode,
                     i_subsys_error, i_cpu_error, i_link_adaptor_irq};
  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge i_clk) begin
        s1[g] <= async_in[g];
        s2[g] <= s1[g];
        s3[g] <= s2[g];
        if (s2[g] == s3[g]) begin
          stable[g] <= s3[g];
        end
      end
    end
  endgenerate

  logic sw_cfg, sw_boot, sw_bank, a24, err_sub, err_cpu, la_irq;
  logic [7:0] strap;
  logic [3:0] sw_hi, sw_mid, sw_lo;
  assign {sw_cfg, sw_boot, sw_bank, strap, sw_hi, sw_mid, sw_lo, a24, err_sub, err_cpu, la_irq} = stable;

  ////////////////////////////////////////////////////////////////////////////
  // Strap decoding
  logic lock_enable;
  assign o_upstream_config_link = sw_cfg ? board_ctrl_pkg::SRC_ADAPTOR :
    (strap[board_ctrl_pkg::STRAP_FRONT] ? board_ctrl_pkg::SRC_FRONT : board_ctrl_pkg::SRC_BACKPLANE);
  assign o_downstream_config_link_front = strap[board_ctrl_pkg::STRAP_FRONT];
  assign o_boot_from_link = sw_boot;
  assign o_boot_from_flash = !sw_boot && sw_bank;
  assign o_link_speed_10m = strap[board_ctrl_pkg::STRAP_SLOW];
  assign o_subsys_fanout_from_site0 = strap[board_ctrl_pkg::STRAP_FANOUT];
  assign o_vme_slave_enable = !strap[board_ctrl_pkg::STRAP_VME_OFF];
  assign o_a32_base = {sw_hi, sw_mid};
  assign o_a24_base = sw_lo[1:0];
  // Lock on reset policy
  assign lock_enable = !strap[board_ctrl_pkg::STRAP_NOLOCK] &&
    (strap[board_ctrl_pkg::STRAP_LOCK_SW2] ? !sw_boot : 1'b1);

  ////////////////////////////////////////////////////////////////////////////
  // Power-on backplane reset
  logic [$clog2(POR_CYCLES+1)-1:0] por_cnt;
  logic por_busy;
  assign por_busy = por_cnt != '0;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      por_cnt <= ($clog2(POR_CYCLES+1))'(POR_CYCLES);
    end else if (por_busy) begin
      por_cnt <= por_cnt - 1'b1;
    end
  end
  assign o_backplane_system_reset = por_busy && !strap[board_ctrl_pkg::STRAP_NO_PORST];

  ////////////////////////////////////////////////////////////////////////////
  // Register decode
  logic [7:0] vme_off, cpu_off;
  assign vme_off = {i_vme_addr[7:2], 2'b00};
  function automatic logic hit(input logic [7:0] off, input logic [7:0] reg_off);
    hit = off == reg_off;
  endfunction : hit
  logic vme_wr, cpu_wr, vme_rd, vme_en;
  assign vme_en = i_vme_sel && o_vme_slave_enable;
  assign vme_wr = vme_en && i_vme_wr;
  assign vme_rd = vme_en && !i_vme_wr;
  assign cpu_off = {i_cpu_addr[7:2], 2'b00};
  assign cpu_wr = i_cpu_sel && i_cpu_wr;
  logic [7:0] wd;
  logic [7:0] woff;
  logic any_wr;
  assign any_wr = vme_wr || cpu_wr;
  assign wd = vme_wr ? i_vme_wdata : i_cpu_wdata;
  assign woff = vme_wr ? vme_off : cpu_off;
  logic release_wr;
  assign release_wr = vme_wr && hit(vme_off, board_ctrl_pkg::OFF_HOLD_RELEASE);

  ////////////////////////////////////////////////////////////////////////////
  // Write strobes
  logic wr_subsys_reset;
  logic wr_subsys_analyse;
  logic wr_cpu_reset;
  logic wr_cpu_analyse;
  logic wr_lamps;
  logic wr_cpu_hold;
  logic wr_bp_hold;
  logic wr_window;
  logic wr_irq_cpu;
  logic wr_irq_bp;
  logic wr_prio;
  logic wr_la_route;
  logic wr_irq_ack;
  logic wr_flash_vpp;
  logic wr_flash_low;
  logic wr_vector;
  assign wr_subsys_reset = any_wr && hit(woff, board_ctrl_pkg::OFF_SUBSYS_RESET);
  assign wr_subsys_analyse = any_wr && hit(woff, board_ctrl_pkg::OFF_SUBSYS_ANALYSE);
  assign wr_cpu_reset = any_wr && hit(woff, board_ctrl_pkg::OFF_CPU_RESET);
  assign wr_cpu_analyse = any_wr && hit(woff, board_ctrl_pkg::OFF_CPU_ANALYSE);
  assign wr_lamps = any_wr && hit(woff, board_ctrl_pkg::OFF_LAMPS);
  assign wr_cpu_hold = any_wr && hit(woff, board_ctrl_pkg::OFF_CPU_HOLD);
  assign wr_bp_hold = any_wr && hit(woff, board_ctrl_pkg::OFF_BP_HOLD);
  assign wr_window = any_wr && hit(woff, board_ctrl_pkg::OFF_WINDOW);
  assign wr_irq_cpu = any_wr && hit(woff, board_ctrl_pkg::OFF_IRQ_CPU);
  assign wr_irq_bp = any_wr && hit(woff, board_ctrl_pkg::OFF_IRQ_BP);
  assign wr_prio = any_wr && hit(woff, board_ctrl_pkg::OFF_IRQ_PRIO);
  assign wr_la_route = any_wr && hit(woff, board_ctrl_pkg::OFF_LA_ROUTE);
  assign wr_irq_ack = any_wr && hit(woff, board_ctrl_pkg::OFF_IRQ_ACK);
  assign wr_flash_vpp = any_wr && hit(woff, board_ctrl_pkg::OFF_FLASH_VPP);
  assign wr_flash_low = any_wr && hit(woff, board_ctrl_pkg::OFF_FLASH_LOW);
  assign wr_vector = vme_wr && hit(vme_off, board_ctrl_pkg::OFF_IRQ_VECTOR);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [1:0] window_sel;
  logic [2:0] prio;
  logic la_route;
  logic irq_cpu;
  logic irq_bp;
  logic cpu_reset;
  logic reset_seen;
  // Policy load one edge after reset, once the synchronisers have settled
  always_ff @(posedge i_clk) begin
    reset_seen <= i_sys_rst;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_subsys_reset <= 1'b0;
    end else if (wr_subsys_reset) begin
      o_subsys_reset <= wd[board_ctrl_pkg::BIT_D0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_subsys_analyse <= 1'b0;
    end else if (wr_subsys_analyse) begin
      o_subsys_analyse <= wd[board_ctrl_pkg::BIT_D0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_cpu_analyse <= 1'b0;
    end else if (wr_cpu_analyse) begin
      o_cpu_analyse <= wd[board_ctrl_pkg::BIT_D0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_panel_lamps <= 3'h0;
    end else if (wr_lamps) begin
      o_panel_lamps <= wd[2:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      window_sel <= 2'h0;
    end else if (wr_window) begin
      window_sel <= wd[1:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      irq_cpu <= 1'b0;
    end else if (wr_irq_cpu) begin
      irq_cpu <= wd[board_ctrl_pkg::BIT_D2];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      irq_bp <= 1'b0;
    end else if (wr_irq_bp) begin
      irq_bp <= wd[board_ctrl_pkg::BIT_D1];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      prio <= 3'h0;
    end else if (wr_prio) begin
      prio <= wd[2:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      la_route <= 1'b0;
    end else if (wr_la_route) begin
      la_route <= wd[board_ctrl_pkg::BIT_D2];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_flash_prog_voltage <= 1'b0;
    end else if (wr_flash_vpp) begin
      o_flash_prog_voltage <= wd[board_ctrl_pkg::BIT_D1];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_flash_low_addr <= 2'h0;
    end else if (wr_flash_low) begin
      o_flash_low_addr <= wd[1:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_backplane_irq_vector_num <= board_ctrl_pkg::RST_BYTE;
    end else if (wr_vector) begin
      o_backplane_irq_vector_num <= wd;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_cpu_irq_ack <= 1'b0;
    end else begin
      o_cpu_irq_ack <= wr_irq_ack;
    end
  end

  // Release from the backplane side beats any write in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_cpu_bus_hold <= 1'b0;
    end else if (release_wr) begin
      o_cpu_bus_hold <= 1'b0;
    end else if (wr_cpu_hold) begin
      o_cpu_bus_hold <= wd[board_ctrl_pkg::BIT_D1];
    end else if (reset_seen) begin
      o_cpu_bus_hold <= lock_enable && !sw_boot && sw_bank;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_backplane_bus_hold <= 1'b0;
    end else if (wr_bp_hold) begin
      o_backplane_bus_hold <= wd[board_ctrl_pkg::BIT_D1];
    end else if (reset_seen) begin
      o_backplane_bus_hold <= lock_enable && !sw_boot && !sw_bank;
    end
  end

  // Processor reset: set by write of one, cleared by any VME write
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cpu_reset <= 1'b0;
    end else if (cpu_reset && vme_wr) begin
      cpu_reset <= 1'b0;
    end else if (wr_cpu_reset) begin
      cpu_reset <= wd[board_ctrl_pkg::BIT_D0];
    end
  end

  assign o_shared_memory_window_base = {window_sel, 20'h00000};
  assign o_cpu_reset = cpu_reset;
  assign o_backplane_irq_priority = prio;
  assign o_cpu_irq = irq_cpu || (la_route && la_irq);
  assign o_backplane_irq = (prio != 3'h0) && (irq_bp || (!la_route && la_irq));

  ////////////////////////////////////////////////////////////////////////////
  // Read mux, low byte only, undefined bits read zero
  function automatic logic [7:0] rd_mux(input logic [7:0] off, input logic from_vme);
    rd_mux = 8'h00;
    unique case (off)
      board_ctrl_pkg::OFF_SUBSYS_RESET: rd_mux = {7'h00, err_sub};
      board_ctrl_pkg::OFF_CPU_ERROR: rd_mux = {7'h00, err_cpu};
      board_ctrl_pkg::OFF_CPU_HOLD: rd_mux = {6'h00, o_cpu_bus_hold, 1'b0};
      board_ctrl_pkg::OFF_BP_HOLD: rd_mux = {6'h00, o_backplane_bus_hold, 1'b0};
      board_ctrl_pkg::OFF_WINDOW: rd_mux = {6'h00, window_sel};
      board_ctrl_pkg::OFF_IRQ_CPU: rd_mux = {5'h00, irq_cpu, 2'h0};
      board_ctrl_pkg::OFF_IRQ_BP: rd_mux = {6'h00, irq_bp, 1'b0};
      board_ctrl_pkg::OFF_IRQ_PRIO: rd_mux = {5'h00, prio};
      board_ctrl_pkg::OFF_LA_ROUTE: rd_mux = {5'h00, la_route, 2'h0};
      board_ctrl_pkg::OFF_IRQ_VECTOR: rd_mux = from_vme ? o_backplane_irq_vector_num : 8'h00;
      default: rd_mux = 8'h00;
    endcase
  endfunction : rd_mux
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_vme_rdata <= 8'h00;
      o_cpu_rdata <= 8'h00;
    end else begin
      if (vme_rd) o_vme_rdata <= rd_mux(vme_off, 1'b1);
      if (i_cpu_sel && !i_cpu_wr) o_cpu_rdata <= rd_mux(cpu_off, 1'b0);
    end
  end

endmodule : board_control_and_strap_logic
`default_nettype wire

// [pkg/board_ctrl_pkg.sv]
// Constants for the board control and strap logic
package board_ctrl_pkg;
  // Register offsets (byte addresses within the control page)
  localparam logic [7:0] OFF_SUBSYS_RESET = 8'h00;
  localparam logic [7:0] OFF_SUBSYS_ANALYSE = 8'h04;
  localparam logic [7:0] OFF_CPU_RESET = 8'h10;
  localparam logic [7:0] OFF_CPU_ANALYSE = 8'h14;
  localparam logic [7:0] OFF_CPU_ERROR = 8'h18;
  localparam logic [7:0] OFF_LAMPS = 8'h1c;
  localparam logic [7:0] OFF_CPU_HOLD = 8'h20;
  localparam logic [7:0] OFF_BP_HOLD = 8'h24;
  localparam logic [7:0] OFF_WINDOW = 8'h28;
  localparam logic [7:0] OFF_IRQ_CPU = 8'h30;
  localparam logic [7:0] OFF_IRQ_BP = 8'h34;
  localparam logic [7:0] OFF_IRQ_PRIO = 8'h38;
  localparam logic [7:0] OFF_LA_ROUTE = 8'h40;
  localparam logic [7:0] OFF_IRQ_ACK = 8'h44;
  localparam logic [7:0] OFF_HOLD_RELEASE = 8'h4c;
  localparam logic [7:0] OFF_FLASH_VPP = 8'h50;
  localparam logic [7:0] OFF_FLASH_LOW = 8'h54;
  localparam logic [7:0] OFF_IRQ_VECTOR = 8'h60;
  // Byte lane offset for VME byte-wide access
  localparam logic [1:0] BYTE_LANE_OFF = 2'h3;
  // Field positions
  localparam int BIT_D0 = 0;
  localparam int BIT_D1 = 1;
  localparam int BIT_D2 = 2;
  // Strap bank bit positions (switch 4.n at index n-1)
  localparam int STRAP_FANOUT = 1;
  localparam int STRAP_NOLOCK = 2;
  localparam int STRAP_LOCK_SW2 = 3;
  localparam int STRAP_SLOW = 4;
  localparam int STRAP_FRONT = 5;
  localparam int STRAP_NO_PORST = 6;
  localparam int STRAP_VME_OFF = 7;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Power-on cycle length for driving the backplane reset
  localparam int POR_TIME_US = 200;
  localparam int CLK_MHZ = 100;
  localparam int POR_CYCLES = POR_TIME_US * CLK_MHZ;
  // Upstream config source codes
  typedef enum logic [1:0] {
    SRC_ADAPTOR = 2'b00,
    SRC_FRONT = 2'b01,
    SRC_BACKPLANE = 2'b10
  } cfg_src_t;
endpackage : board_ctrl_pkg

// [bench/reg_master.sv]
// Bus master model for one control register port
`timescale 1ns/1ps
`default_nettype none
module reg_master (
  // Clock
  input wire logic i_clk,
  // Access strobe towards the block
  output logic o_sel,
  output logic o_wr,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  // Read data
  input wire logic [7:0] i_rdata
);
  initial begin
    o_sel = 1'b0;
    o_wr = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  ////////////////////////////////////////////////////////////////
  // One access: strobe taken at one edge, read data an edge later
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] m,
      output logic [7:0] q);
    @(posedge i_clk);
    o_sel <= 1'b1;
    o_wr <= w;
    o_addr <= a;
    o_wdata <= d & m;
    @(posedge i_clk);
    o_sel <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~(d & m);
    @(posedge i_clk);
    #1;
    q = i_rdata & m;
  endtask : acc
endmodule : reg_master
`default_nettype wire

// [bench/board_ctrl_chk.sv]
// Assertions on the board control and strap logic ports
`timescale 1ns/1ps
`default_nettype none
module board_ctrl_chk (
  // Clock, reset and inputs
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_config_source_switch,
  input wire logic i_boot_mode_switch,
  input wire logic i_boot_bank_switch,
  input wire logic [7:0] i_strap_bank,
  input wire logic i_vme_sel,
  input wire logic i_vme_wr,
  input wire logic [7:0] i_vme_addr,
  input wire logic i_cpu_sel,
  input wire logic i_cpu_wr,
  input wire logic [7:0] i_cpu_addr,
  // Outputs
  input wire logic o_vme_slave_enable,
  input wire logic [1:0] o_upstream_config_link,
  input wire logic o_downstream_config_link_front,
  input wire logic o_boot_from_link,
  input wire logic o_boot_from_flash,
  input wire logic o_cpu_reset,
  input wire logic o_cpu_bus_hold,
  input wire logic o_backplane_irq,
  input wire logic [2:0] o_backplane_irq_priority,
  input wire logic o_cpu_irq_ack
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_calm;
    ($stable(i_strap_bank) && $stable(i_config_source_switch) && $stable(i_boot_mode_switch)
      && $stable(i_boot_bank_switch)) [*5];
  endsequence
  sequence s_vme_wr;
    i_vme_sel && i_vme_wr && o_vme_slave_enable && !i_cpu_sel;
  endsequence
  ////////////////////////////////////////////////////////////////
  a_slave_en_strap: assert property (s_calm |-> o_vme_slave_enable == !i_strap_bank[7])
    else $error("slave enable wrong");
  a_down_link_front: assert property (s_calm |-> o_downstream_config_link_front == i_strap_bank[5])
    else $error("downstream route wrong");
  a_up_link_route: assert property (s_calm |-> o_upstream_config_link ==
    (i_config_source_switch ? 2'h0 : (i_strap_bank[5] ? 2'h1 : 2'h2))) else $error("upstream route wrong");
  a_boot_source_sel: assert property (s_calm |-> o_boot_from_link == i_boot_mode_switch &&
    (i_boot_mode_switch || o_boot_from_flash == i_boot_bank_switch)) else $error("boot source wrong");
  a_irq_level_gate: assert property (o_backplane_irq |-> o_backplane_irq_priority != 3'h0)
    else $error("irq at level zero");
  a_ack_one_pulse: assert property (i_cpu_sel && i_cpu_wr && i_cpu_addr[7:2] == 6'h11
    |-> ##[1:2] o_cpu_irq_ack ##1 !o_cpu_irq_ack) else $error("ack pulse wrong");
  a_hold_release_wr: assert property (s_vme_wr ##0 i_vme_addr[7:2] == 6'h13 |=> !o_cpu_bus_hold)
    else $error("hold not released");
  a_reset_vme_clear: assert property (o_cpu_reset ##0 s_vme_wr ##0 i_vme_addr[7:2] != 6'h04
    |=> !o_cpu_reset) else $error("cpu reset not cleared");
endmodule : board_ctrl_chk
bind board_control_and_strap_logic board_ctrl_chk u_chk (.*);
`default_nettype wire

// [bench/tb_board_control_and_strap_logic.sv]
// Self-checking bench for the board control and strap logic
`timescale 1ns/1ps
`default_nettype none
module tb_board_control_and_strap_logic;
  logic i_clk, i_sys_rst, sw_cfg, sw_boot, sw_bank, se, ce, lai, vs, vw, cs, cw;
  logic [7:0] straps, q, va, vd, vr, ca, cd, cr, a32;
  logic [3:0] hi;
  logic [1:0] a24, up;
  logic [21:0] win;
  logic [2:0] prio, lamps;
  logic ven, dfront, blink, bflash, spd, fan, bprst, sreset, creset, chold, bhold, cirq, birq;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  logic [7:0] tab_s [5] = '{8'h00, 8'hfe, 8'h08, 8'h08, 8'h08};
  logic [2:0] tab_w [5] = '{3'b101, 3'b001, 3'b110, 3'b000, 3'b101};
  logic [1:0] tab_h [5] = '{2'b10, 2'b00, 2'b00, 2'b01, 2'b10};
  board_control_and_strap_logic #(.POR_CYCLES(10)) uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_config_source_switch(sw_cfg), .i_boot_mode_switch(sw_boot), .i_boot_bank_switch(sw_bank),
    .i_strap_bank(straps), .i_base_addr_switch_hi(hi), .i_base_addr_switch_mid(4'h8),
    .i_base_addr_switch_lo(4'h5), .i_a24_mode(1'b1), .i_vme_sel(vs), .i_vme_wr(vw), .i_vme_addr(va),
    .i_vme_wdata(vd), .o_vme_rdata(vr), .i_cpu_sel(cs), .i_cpu_wr(cw), .i_cpu_addr(ca), .i_cpu_wdata(cd),
    .o_cpu_rdata(cr), .i_subsys_error(se), .i_cpu_error(ce), .i_link_adaptor_irq(lai),
    .i_a24_window_req(2'h0), .o_a32_base(a32), .o_a24_base(a24), .o_shared_memory_window_base(win),
    .o_vme_slave_enable(ven), .o_upstream_config_link(up), .o_downstream_config_link_front(dfront),
    .o_boot_from_link(blink), .o_boot_from_flash(bflash), .o_link_speed_10m(spd),
    .o_subsys_fanout_from_site0(fan), .o_backplane_system_reset(bprst), .o_subsys_reset(sreset),
    .o_subsys_analyse(), .o_cpu_reset(creset), .o_cpu_analyse(), .o_panel_lamps(lamps),
    .o_cpu_bus_hold(chold), .o_backplane_bus_hold(bhold), .o_cpu_irq(cirq), .o_backplane_irq(birq),
    .o_backplane_irq_priority(prio), .o_backplane_irq_vector_num(), .o_cpu_irq_ack(),
    .o_flash_prog_voltage(), .o_flash_low_addr());
  reg_master vm (.i_clk(i_clk), .o_sel(vs), .o_wr(vw), .o_addr(va), .o_wdata(vd), .i_rdata(vr));
  reg_master cm (.i_clk(i_clk), .o_sel(cs), .o_wr(cw), .o_addr(ca), .o_wdata(cd), .i_rdata(cr));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    {i_sys_rst, se, ce, lai, straps, hi, sw_cfg, sw_boot, sw_bank} = '1;
    for (int k = 0; k < 5; k++) begin
      @(posedge i_clk);
      i_sys_rst <= 1'b1;
      straps <= tab_s[k];
      {sw_cfg, sw_boot, sw_bank} <= tab_w[k];
      hi <= 4'(k);
      repeat (6) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      repeat (2) @(posedge i_clk);
      #1;
      chk(bprst, !tab_s[k][6]);
      chk({chold, bhold}, tab_h[k]);
      chk({ven, spd, fan, dfront}, {!tab_s[k][7], tab_s[k][4], tab_s[k][1], tab_s[k][5]});
      chk(up, sw_cfg ? 2'h0 : (tab_s[k][5] ? 2'h1 : 2'h2));
      chk({blink, bflash | sw_boot}, {sw_boot, sw_bank | sw_boot});
      chk({a32, a24}, {hi, 4'h8, 2'h1});
      if (k == 3) vm.acc(1'b1, 8'h24, 8'h00, 8'h02, q);
      chk(bhold, 1'b0);
      repeat (12) @(posedge i_clk);
      chk(bprst, 1'b0);
    end
    vm.acc(1'b1, 8'h4c, 8'h5a, 8'hff, q);
    chk(chold, 1'b0);
    vm.acc(1'b1, 8'h27, 8'h02, 8'h02, q);
    chk(bhold, 1'b1);
    vm.acc(1'b0, 8'h24, 8'h00, 8'h02, q);
    chk(q, 8'h02);
    vm.acc(1'b1, 8'h24, 8'h00, 8'h02, q);
    chk(bhold, 1'b0);
    vm.acc(1'b1, 8'h13, 8'h01, 8'h01, q);
    chk(creset, 1'b1);
    vm.acc(1'b1, 8'h10, 8'h00, 8'h01, q);
    chk(creset, 1'b0);
    cm.acc(1'b1, 8'h10, 8'h01, 8'h01, q);
    chk(creset, 1'b1);
    vm.acc(1'b1, 8'h4c, 8'h00, 8'hff, q);
    chk(creset, 1'b0);
    @(posedge i_clk);
    {se, ce} <= 2'b01;
    cm.acc(1'b1, 8'h00, 8'h01, 8'h01, q);
    cm.acc(1'b0, 8'h00, 8'h00, 8'h01, q);
    chk({sreset, q}, {1'b1, 8'h00});
    cm.acc(1'b0, 8'h18, 8'h00, 8'h01, q);
    chk(q, 8'h01);
    cm.acc(1'b1, 8'h1c, 8'h05, 8'h07, q);
    chk(lamps, 3'h5);
    vm.acc(1'b1, 8'h34, 8'h02, 8'h02, q);
    for (int v = 0; v < 8; v++) begin
      vm.acc(1'b1, 8'h38, 8'(v), 8'h07, q);
      chk({prio, birq}, {3'(v), v != 0});
    end
    vm.acc(1'b1, 8'h34, 8'h00, 8'h02, q);
    cm.acc(1'b1, 8'h40, 8'h04, 8'h04, q);
    chk({cirq, birq}, 2'b10);
    cm.acc(1'b1, 8'h40, 8'h00, 8'h04, q);
    chk({cirq, birq}, 2'b01);
    vm.acc(1'b1, 8'h30, 8'h04, 8'h04, q);
    chk(cirq, 1'b1);
    cm.acc(1'b1, 8'h44, 8'h77, 8'hff, q);
    cm.acc(1'b1, 8'h28, 8'h03, 8'h03, q);
    cm.acc(1'b0, 8'h28, 8'h00, 8'h03, q);
    chk({win, q}, {22'h300000, 8'h03});
    cm.acc(1'b0, 8'h0c, 8'h00, 8'hff, q);
    chk(q, 8'h00);
    summarize();
  end
endmodule : tb_board_control_and_strap_logic
`default_nettype wire
